/* File: design/csc_pkg.sv */
// package for the clock source and start-up controller
// assumes a 20 MHz hclk and an AHB-Lite master with single word transfers
package csc_pkg;

    // register byte addresses
    localparam logic [7:0] ADDR_FUSE   = 8'h00;
    localparam logic [7:0] ADDR_CTRL   = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;

    // fuse register layout
    localparam int FUSE_SRC_LSB = 0;
    localparam int FUSE_SUT_LSB = 4;
    localparam int FUSE_DIV_BIT = 6;
    localparam logic [31:0] FUSE_RESET = 32'h0000_0022;
    localparam logic [6:0]  FUSE_MASK  = 7'h7F;

    // control register layout
    localparam int CTRL_MODE_LSB  = 0;
    localparam int CTRL_SLEEP_BIT = 2;

    // status register layout
    localparam int ST_STATE_LSB  = 0;
    localparam int ST_RSVD_BIT   = 3;
    localparam int ST_RANGE_LSB  = 4;
    localparam int ST_RESET_BIT  = 7;
    localparam int ST_RUN_BIT    = 8;
    localparam int ST_MODE_LSB   = 10;
    localparam int ST_CLASS_LSB  = 12;

    // clock source codes
    localparam logic [3:0] SRC_RC   = 4'h2;
    localparam logic [3:0] SRC_EXT  = 4'h0;

    // cycle counts of the selected oscillator and the watchdog oscillator
    localparam int CNT_W          = 17;
    localparam int OSC_CK_SHORT   = 6;
    localparam int OSC_CK_258     = 258;
    localparam int OSC_CK_1K      = 1024;
    localparam int WDT_CK_4K      = 4096;
    localparam logic [2:0] DIV8_LOG2 = 3'h3;
    localparam logic [2:0] DIV1_LOG2 = 3'h0;

    typedef enum logic [2:0] {
        CLS_XTAL = 3'b000,
        CLS_LF   = 3'b001,
        CLS_RC   = 3'b010,
        CLS_EXT  = 3'b011,
        CLS_RSVD = 3'b100
    } csc_class_e;

    typedef enum logic [1:0] {
        SLP_NONE   = 2'b00,
        SLP_IDLE   = 2'b01,
        SLP_SAVE   = 2'b10,
        SLP_DOWN   = 2'b11
    } csc_sleep_e;

    typedef enum logic [2:0] {
        ST_START = 3'b000,
        ST_WAIT  = 3'b001,
        ST_RUN   = 3'b010,
        ST_SLEEP = 3'b011
    } csc_state_e;

endpackage

/* File: design/csc_sync.sv */
// two flip-flop synchroniser for pin inputs
// assumes inputs are asynchronous to hclk
`timescale 1ns/1ns
module csc_sync #(
    parameter int W = 1
) (
    input  wire logic         hclk,
    input  wire logic         hresetn,
    input  wire logic [W-1:0] pin,
    output logic      [W-1:0] level
);
    logic [W-1:0] meta_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_q <= '0;
            level  <= '0;
        end else begin
            meta_q <= pin;
            level  <= meta_q;
        end
    end
endmodule

/* File: design/csc_tick_counter.sv */
// counts tick pulses up to a loaded target and flags completion
// assumes tick is a one-cycle pulse on hclk
`timescale 1ns/1ns
module csc_tick_counter (
    input  wire logic                      hclk,
    input  wire logic                      hresetn,
    input  wire logic                      start,
    input  wire logic [csc_pkg::CNT_W-1:0] target,
    input  wire logic                      tick,
    output logic                           done_q
);
    logic [csc_pkg::CNT_W-1:0] count_q;
    logic [csc_pkg::CNT_W-1:0] target_q;
    wire  [csc_pkg::CNT_W-1:0] count_inc = count_q + 1'b1;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_q  <= '0;
            target_q <= '0;
            done_q   <= 1'b0;
        end else if (start) begin
            count_q  <= '0;
            target_q <= target;
            done_q   <= (target == '0);
        end else if (!done_q && tick) begin
            count_q  <= count_inc;
            done_q   <= (count_inc == target_q);
        end
    end
endmodule

/* File: design/csc_clock_control.sv */
// clock source selection and start-up sequencing with AHB-Lite registers
// assumes oscillator pins carry free square waves slower than hclk / 4
`timescale 1ns/1ns
// Operation
// - the four source fuse bits pick crystal, low-frequency crystal, RC, external or reserved.
// - waking from power-down or power-save waits a count of selected oscillator cycles.
// - starting from reset also waits none, 4,096 or 65,536 watchdog cycles as the fuses say.
// - fuses come up as source 0010, start-up 10 and the divide-by-eight fuse programmed.
// - in crystal mode the upper three source bits pick the oscillator frequency range.
// - with the low source bit clear, start-up codes give 258 or 1K cycles plus delays.
// - with the low source bit set, start-up codes give 1K or 16K cycles plus delays.
// - the core clock is off outside run, so the core does nothing then.
// - the peripheral clock runs in idle, and a wake pin is seen with it halted.
// - the program store clock is on exactly when the core clock is on.
// - the async timer clock keeps running in sleep, stopping only in power-down.
// - each sleep mode gates off the clocks of modules it does not need.
module csc_clock_control #(
    parameter int OSC_CK_16K   = 16384,
    parameter int OSC_CK_32K   = 32768,
    parameter int WDT_CK_64K   = 65536
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        osc_pin,
    input  wire logic        wdt_osc_pin,
    input  wire logic        async_xtal_pin,
    input  wire logic        wake_pin,
    output logic             core_clock,
    output logic             peripheral_clock,
    output logic             program_store_clock,
    output logic             async_timer_clock,
    output logic [3:0]       clock_source_select_fuses,
    output logic [2:0]       crystal_range_select,
    output logic [2:0]       sys_clk_div_log2
);
    // pin synchronisers and edge detect on the second stage
    logic [3:0] pins_s;
    logic [3:0] pins_prev_q;
    wire  [3:0] pins_rise = pins_s & ~pins_prev_q;

    csc_sync #(
        .W (4)
    ) u_sync (
        .hclk    (hclk),
        .hresetn (hresetn),
        .pin     ({wake_pin, async_xtal_pin, wdt_osc_pin, osc_pin}),
        .level   (pins_s)
    );

    wire osc_tick  = pins_rise[0];
    wire wdt_tick  = pins_rise[1];
    wire wake_evt  = pins_rise[3];

    // source class and start-up count decoding
    function automatic csc_pkg::csc_class_e src_class(input logic [3:0] src);
        if (src[3])
            src_class = csc_pkg::CLS_XTAL;
        else if (src[2])
            src_class = csc_pkg::CLS_LF;
        else if (src == csc_pkg::SRC_RC)
            src_class = csc_pkg::CLS_RC;
        else if (src == csc_pkg::SRC_EXT)
            src_class = csc_pkg::CLS_EXT;
        else
            src_class = csc_pkg::CLS_RSVD;
    endfunction

    function automatic logic [csc_pkg::CNT_W-1:0] osc_count(input logic [3:0] src,
                                                            input logic [1:0] startup_time_fuses);
        int n;
        n = csc_pkg::OSC_CK_SHORT;
        case (src_class(src))
            csc_pkg::CLS_XTAL: begin
                if (!src[0])
                    n = startup_time_fuses[1] ? csc_pkg::OSC_CK_1K : csc_pkg::OSC_CK_258;
                else
                    n = (startup_time_fuses == 2'b00) ? csc_pkg::OSC_CK_1K : OSC_CK_16K;
            end
            csc_pkg::CLS_LF: n = src[0] ? OSC_CK_32K : csc_pkg::OSC_CK_1K;
            default: n = csc_pkg::OSC_CK_SHORT;
        endcase
        osc_count = n[csc_pkg::CNT_W-1:0];
    endfunction

    function automatic logic [csc_pkg::CNT_W-1:0] wdt_count(input logic [3:0] src,
                                                            input logic [1:0] startup_time_fuses);
        int n;
        n = 0;
        if (src_class(src) == csc_pkg::CLS_XTAL) begin
            case ({src[0], startup_time_fuses})
                3'b000, 3'b011, 3'b110: n = csc_pkg::WDT_CK_4K;
                3'b001, 3'b100, 3'b111: n = WDT_CK_64K;
                default:                n = 0;
            endcase
        end else begin
            case (startup_time_fuses)
                2'b00:   n = 0;
                2'b01:   n = csc_pkg::WDT_CK_4K;
                default: n = WDT_CK_64K;
            endcase
        end
        wdt_count = n[csc_pkg::CNT_W-1:0];
    endfunction

    // AHB-Lite slave, zero wait states
    logic [7:0]  addr_q;
    logic        wr_q;
    logic [6:0]  fuse_q;
    logic [1:0]  mode_q;
    wire         access  = hsel && htrans[1] && hready;
    wire  [7:0]  addr_a  = haddr[7:0];
    wire         wr_fuse = wr_q && (addr_q == csc_pkg::ADDR_FUSE);
    wire         wr_ctrl = wr_q && (addr_q == csc_pkg::ADDR_CTRL);
    wire         sleep_req = wr_ctrl && hwdata[csc_pkg::CTRL_SLEEP_BIT];

    wire  [3:0]  fuse_src = fuse_q[csc_pkg::FUSE_SRC_LSB +: 4];
    wire  [1:0]  fuse_sut = fuse_q[csc_pkg::FUSE_SUT_LSB +: 2];

    // sequencer state
    csc_pkg::csc_state_e state_q;
    csc_pkg::csc_state_e state_d;
    logic        from_reset_q;
    logic        start_pulse;
    logic        osc_done;
    logic        wdt_done;
    logic [3:0]  act_src_q;

    wire  csc_pkg::csc_sleep_e slp = csc_pkg::csc_sleep_e'(mode_q);
    wire  csc_pkg::csc_class_e act_cls = src_class(act_src_q);

    logic [31:0] status_w;
    assign status_w = {16'h0,
                       1'b0, act_cls,
                       mode_q,
                       1'b0, core_clock,
                       from_reset_q,
                       act_src_q[3:1],
                       act_cls == csc_pkg::CLS_RSVD,
                       state_q};

    wire  [31:0] rdata_w = (addr_a == csc_pkg::ADDR_FUSE)   ? {25'h0, fuse_q} :
                           (addr_a == csc_pkg::ADDR_CTRL)   ? {30'h0, mode_q} :
                           (addr_a == csc_pkg::ADDR_STATUS) ? status_w : 32'h0000_0000;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_q    <= 8'h00;
            wr_q      <= 1'b0;
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            addr_q    <= addr_a;
            wr_q      <= access && hwrite;
            hrdata    <= (access && !hwrite) ? rdata_w : 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // fuse image, shipped default on reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            fuse_q <= csc_pkg::FUSE_RESET[6:0];
        else if (wr_fuse)
            fuse_q <= hwdata[6:0] & csc_pkg::FUSE_MASK;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            mode_q <= 2'b00;
        else if (wr_ctrl)
            mode_q <= hwdata[csc_pkg::CTRL_MODE_LSB +: 2];
    end

    // start-up counters: selected oscillator and watchdog oscillator
    assign start_pulse = (state_q == csc_pkg::ST_START);

    csc_tick_counter u_osc_cnt (
        .hclk    (hclk),
        .hresetn (hresetn),
        .start   (start_pulse),
        .target  (osc_count(fuse_src, fuse_sut)),
        .tick    (osc_tick),
        .done_q  (osc_done)
    );

    csc_tick_counter u_wdt_cnt (
        .hclk    (hclk),
        .hresetn (hresetn),
        .start   (start_pulse),
        .target  (from_reset_q ? wdt_count(fuse_src, fuse_sut) : '0),
        .tick    (wdt_tick),
        .done_q  (wdt_done)
    );

    // sequencer
    always_comb begin
        state_d = state_q;
        case (state_q)
            csc_pkg::ST_START: state_d = csc_pkg::ST_WAIT;
            csc_pkg::ST_WAIT: begin
                if (osc_done && wdt_done)
                    state_d = csc_pkg::ST_RUN;
            end
            csc_pkg::ST_RUN: begin
                if (sleep_req && hwdata[1:0] != csc_pkg::SLP_NONE)
                    state_d = csc_pkg::ST_SLEEP;
            end
            csc_pkg::ST_SLEEP: begin
                if (wake_evt)
                    state_d = (slp == csc_pkg::SLP_IDLE) ? csc_pkg::ST_RUN
                                                         : csc_pkg::ST_START;
            end
            default: state_d = csc_pkg::ST_START;
        endcase
    end

    wire run_d   = (state_d == csc_pkg::ST_RUN);
    wire sleep_d = (state_d == csc_pkg::ST_SLEEP);
    wire [1:0] mode_d = wr_ctrl ? hwdata[1:0] : mode_q;
    wire idle_d  = sleep_d && (mode_d == csc_pkg::SLP_IDLE);
    wire [3:0] sel_src = start_pulse ? fuse_src : act_src_q;
    wire csc_pkg::csc_class_e sel_cls = src_class(sel_src);
    wire down_d  = sleep_d && (mode_d == csc_pkg::SLP_DOWN);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q      <= csc_pkg::ST_START;
            from_reset_q <= 1'b1;
            pins_prev_q  <= 4'h0;
        end else begin
            state_q      <= state_d;
            pins_prev_q  <= pins_s;
            if (state_q == csc_pkg::ST_SLEEP && state_d == csc_pkg::ST_START)
                from_reset_q <= 1'b0;
        end
    end

    // snapshot of source fuses taken at each start-up, divide fuse only at reset start-up
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            act_src_q        <= csc_pkg::SRC_RC;
            sys_clk_div_log2 <= csc_pkg::DIV1_LOG2;
        end else if (start_pulse) begin
            act_src_q <= fuse_src;
            if (from_reset_q)
                sys_clk_div_log2 <= fuse_q[csc_pkg::FUSE_DIV_BIT] ? csc_pkg::DIV1_LOG2
                                                                  : csc_pkg::DIV8_LOG2;
        end
    end

    // clock enables and oscillator selects
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            core_clock                <= 1'b0;
            peripheral_clock          <= 1'b0;
            program_store_clock       <= 1'b0;
            async_timer_clock         <= 1'b0;
            clock_source_select_fuses <= csc_pkg::SRC_RC;
            crystal_range_select      <= 3'h0;
        end else begin
            core_clock                <= run_d;
            peripheral_clock          <= run_d || idle_d;
            program_store_clock       <= run_d;
            async_timer_clock         <= !down_d;
            clock_source_select_fuses <= sel_src;
            crystal_range_select      <= (sel_cls == csc_pkg::CLS_XTAL) ? sel_src[3:1]
                                                                       : 3'h0;
        end
    end

endmodule

/* File: sim/csc_osc_model.sv */
// free-running oscillator waves that the clock controller sees on its pins
// assumes the controller samples them on hclk; every wave is slower than hclk / 4
`timescale 1ns/1ns
module csc_osc_model #(
    parameter int OSC_HALF_NS = 150,
    parameter int WDT_HALF_NS = 200,
    parameter int ASY_HALF_NS = 15625
) (
    output logic osc_pin,
    output logic wdt_osc_pin,
    output logic async_xtal_pin
);
    // selected source, counted on wake and on reset start-up
    initial begin
        osc_pin = 1'b0;
        forever #(OSC_HALF_NS) osc_pin = ~osc_pin;
    end
    // watchdog oscillator, times the reset delay
    initial begin
        wdt_osc_pin = 1'b0;
        forever #(WDT_HALF_NS) wdt_osc_pin = ~wdt_osc_pin;
    end
    // 32 kHz crystal, runs on through sleep
    initial begin
        async_xtal_pin = 1'b0;
        forever #(ASY_HALF_NS) async_xtal_pin = ~async_xtal_pin;
    end
endmodule

/* File: sim/csc_clock_control_chk.sv */
// concurrent checks on the ports of the clock controller
// assumes one hclk domain and the active-low asynchronous hresetn
`timescale 1ns/1ns
module csc_clock_control_chk #(
    parameter int OSC_CK_16K = 16384,
    parameter int OSC_CK_32K = 32768,
    parameter int WDT_CK_64K = 65536
) (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    input wire logic        osc_pin,
    input wire logic        wdt_osc_pin,
    input wire logic        async_xtal_pin,
    input wire logic        wake_pin,
    input wire logic        core_clock,
    input wire logic        peripheral_clock,
    input wire logic        program_store_clock,
    input wire logic        async_timer_clock,
    input wire logic [3:0]  clock_source_select_fuses,
    input wire logic [2:0]  crystal_range_select,
    input wire logic [2:0]  sys_clk_div_log2
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic        wdt_prev_q;
    logic [31:0] wdt_cnt_q;
    logic        ctrl_wr_q;
    wire         rd_take = hsel && htrans[1] && hready && !hwrite;
    wire         ctrl_take = hsel && htrans[1] && hready && hwrite
                             && (haddr[7:0] == csc_pkg::ADDR_CTRL);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wdt_prev_q <= 1'b0;
            wdt_cnt_q  <= 32'h0;
            ctrl_wr_q  <= 1'b0;
        end else begin
            wdt_prev_q <= wdt_osc_pin;
            wdt_cnt_q  <= wdt_cnt_q + {31'h0, wdt_osc_pin && !wdt_prev_q};
            ctrl_wr_q  <= ctrl_take;
        end
    end
    a_bus_okay: assert property (hreadyout && !hresp) else $error("bus not ready or not okay");
    a_rdata_idle: assert property (!$past(rd_take) |-> hrdata == 32'h0)
        else $error("read data outside data phase");
    a_store_follows: assert property (program_store_clock == core_clock)
        else $error("program store clock differs from core clock");
    a_core_periph: assert property ($rose(core_clock) |-> peripheral_clock)
        else $error("core enabled without peripheral");
    a_rise_together: assert property ($rose(peripheral_clock) |-> $rose(core_clock))
        else $error("peripheral released alone");
    a_core_halt: assert property (core_clock |-> peripheral_clock && async_timer_clock)
        else $error("core runs with other clocks gated");
    a_async_runs: assert property (peripheral_clock |-> async_timer_clock)
        else $error("async timer clock off while awake");
    a_range_xtal: assert property (clock_source_select_fuses[3]
        |-> crystal_range_select == clock_source_select_fuses[3:1])
        else $error("crystal range wrong");
    a_range_other: assert property (!clock_source_select_fuses[3]
        |-> crystal_range_select == 3'h0) else $error("range set for non-crystal source");
    a_div_reset: assert property (core_clock |-> sys_clk_div_log2 == csc_pkg::DIV8_LOG2)
        else $error("system divide not eight");
    a_wdt_delay: assert property ($rose(core_clock) |-> wdt_cnt_q >= WDT_CK_64K)
        else $error("core released before watchdog delay");
    a_idle_wake: assert property (peripheral_clock && !core_clock && $rose(wake_pin)
        |-> ##[1:6] core_clock) else $error("idle wake too slow");
    a_sleep_entry: assert property (ctrl_wr_q && hwdata[2] && hwdata[1:0] != 2'h0
        && core_clock |=> !core_clock) else $error("sleep write did not stop core");
endmodule
bind csc_clock_control csc_clock_control_chk #(
    .OSC_CK_16K(OSC_CK_16K), .OSC_CK_32K(OSC_CK_32K), .WDT_CK_64K(WDT_CK_64K)
) u_csc_clock_control_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .osc_pin(osc_pin),
    .wdt_osc_pin(wdt_osc_pin), .async_xtal_pin(async_xtal_pin), .wake_pin(wake_pin),
    .core_clock(core_clock), .peripheral_clock(peripheral_clock),
    .program_store_clock(program_store_clock), .async_timer_clock(async_timer_clock),
    .clock_source_select_fuses(clock_source_select_fuses),
    .crystal_range_select(crystal_range_select), .sys_clk_div_log2(sys_clk_div_log2)
);

/* File: sim/csc_clock_control_tb.sv */
// self-checking bench for the clock controller, registers over AHB-Lite
// assumes the oscillator model drives the pins and hclk runs at 20 MHz
`timescale 1ns/1ns
module csc_clock_control_tb;
    localparam int L16 = 16;
    localparam int L32 = 32;
    localparam int W64 = 64;
    typedef struct {
        logic [6:0] fuse;
        logic [1:0] mode;
        logic [2:0] cls;
        int         cnt;
    } csc_row_s;
    logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, wake_pin;
    logic [31:0] haddr, hwdata, hrdata, rd, ex;
    logic [1:0]  htrans;
    logic [2:0]  hsize, range_sel, div_log2;
    logic [3:0]  src_sel;
    logic        osc_pin, wdt_osc_pin, async_xtal_pin;
    logic        core_clock, peripheral_clock, program_store_clock, async_timer_clock;
    int          fails, compares, osc_n, wdt_n;
    csc_row_s    rows [11];
    assign hready = hreadyout;
    csc_osc_model u_csc_osc_model (.osc_pin(osc_pin), .wdt_osc_pin(wdt_osc_pin),
        .async_xtal_pin(async_xtal_pin));
    csc_clock_control #(.OSC_CK_16K(L16), .OSC_CK_32K(L32), .WDT_CK_64K(W64))
    u_csc_clock_control (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .osc_pin(osc_pin),
        .wdt_osc_pin(wdt_osc_pin), .async_xtal_pin(async_xtal_pin), .wake_pin(wake_pin),
        .core_clock(core_clock), .peripheral_clock(peripheral_clock),
        .program_store_clock(program_store_clock), .async_timer_clock(async_timer_clock),
        .clock_source_select_fuses(src_sel), .crystal_range_select(range_sel),
        .sys_clk_div_log2(div_log2));
    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end
    always @(posedge osc_pin) osc_n++;
    always @(posedge wdt_osc_pin) wdt_n++;
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp_rng(input int got, input int lo, input int hi);
        compares++;
        if (got < lo || got > hi) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, lo);
        end
    endtask
    task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1; haddr <= {24'h0, a}; htrans <= 2'h2; hwrite <= w; hsize <= 3'h2;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic wait_core(input int lim);
        int i;
        i = 0;
        while (core_clock !== 1'b1 && i < lim) begin
            @(posedge hclk);
            i++;
        end
        cmp({31'h0, core_clock}, 32'h1);
    endtask
    task automatic wake();
        @(posedge hclk);
        wake_pin <= 1'b1;
        osc_n = 0;
        repeat (4) @(posedge hclk);
        wake_pin <= 1'b0;
    endtask
    task automatic reset_check();
        cmp({28'h0, src_sel}, {28'h0, csc_pkg::SRC_RC});
        cmp({29'h0, range_sel}, 32'h0);
        cmp({29'h0, core_clock, peripheral_clock, program_store_clock}, 32'h0);
        cmp(hrdata, 32'h0);
    endtask
    task automatic start_check();
        wait_core(W64 * 8 + 400);
        cmp_rng(wdt_n, W64, W64 + 2);
        #1 cmp({30'h0, peripheral_clock, program_store_clock}, 32'h3);
        cmp({29'h0, div_log2}, {29'h0, csc_pkg::DIV8_LOG2});
        ahb(csc_pkg::ADDR_FUSE, 1'b0, 32'h0);
        cmp(rd, csc_pkg::FUSE_RESET);
        ahb(csc_pkg::ADDR_STATUS, 1'b0, 32'h0);
        cmp(rd & 32'h87, 32'h82);
    endtask
    task automatic stop_test();
        if (fails == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        #4000000;
        fails++;
        stop_test();
    end
    initial begin
        // ceramic resonator fitted, so range 100 and 258-cycle codes are fair
        rows = '{'{7'h48, 2'h3, 3'h0, 258}, '{7'h6A, 2'h2, 3'h0, 1024},
                 '{7'h4D, 2'h3, 3'h0, 1024}, '{7'h5F, 2'h2, 3'h0, L16},
                 '{7'h7B, 2'h3, 3'h0, L16}, '{7'h44, 2'h2, 3'h1, 1024},
                 '{7'h45, 2'h3, 3'h1, L32}, '{7'h42, 2'h2, 3'h2, 6},
                 '{7'h40, 2'h3, 3'h3, 6}, '{7'h43, 2'h2, 3'h4, 6}, '{7'h41, 2'h3, 3'h4, 6}};
        hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
        hsize = 3'h2; hwdata = 32'h0; wake_pin = 1'b0; fails = 0; compares = 0; rd = 32'h0;
        repeat (12) @(posedge hclk);
        reset_check();
        hresetn <= 1'b1;
        wdt_n = 0;
        start_check();
        foreach (rows[k]) begin
            ahb(csc_pkg::ADDR_FUSE, 1'b1, {25'h0, rows[k].fuse});
            ahb(csc_pkg::ADDR_FUSE, 1'b0, 32'h0);
            cmp(rd, {25'h0, rows[k].fuse});
            ahb(csc_pkg::ADDR_CTRL, 1'b1, {29'h0, 1'b1, rows[k].mode});
            #1 cmp({29'h0, core_clock, peripheral_clock, async_timer_clock},
                   {31'h0, rows[k].mode == 2'h2});
            wake();
            wait_core(20000);
            cmp_rng(osc_n, rows[k].cnt, rows[k].cnt + 2);
            #1 cmp({28'h0, src_sel}, {28'h0, rows[k].fuse[3:0]});
            ex = rows[k].fuse[3] ? {29'h0, rows[k].fuse[3:1]} : 32'h0;
            cmp({29'h0, range_sel}, ex);
            cmp({29'h0, div_log2}, {29'h0, csc_pkg::DIV8_LOG2});
            ahb(csc_pkg::ADDR_STATUS, 1'b0, 32'h0);
            ex = {17'h0, rows[k].cls, rows[k].mode, 1'b0, 1'b1, 1'b0,
                  rows[k].fuse[3:1], rows[k].cls == 3'h4, 3'h2};
            cmp(rd, ex);
        end
        ahb(csc_pkg::ADDR_CTRL, 1'b1, 32'h5);
        #1 cmp({29'h0, core_clock, peripheral_clock, async_timer_clock}, 32'h3);
        wake();
        wait_core(10);
        ahb(8'h0C, 1'b1, 32'hFFFF_FFFF);
        ahb(8'h0C, 1'b0, 32'h0);
        cmp(rd, 32'h0);
        wake();
        ahb(csc_pkg::ADDR_STATUS, 1'b0, 32'h0);
        cmp(rd & 32'h107, 32'h102);
        @(posedge hclk);
        hresetn <= 1'b0;
        #1 reset_check();
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        wdt_n = 0;
        start_check();
        stop_test();
    end
endmodule
